// *** src/scr_regs.sv ***
// What this block does
// - The latency field changes only on a write that also sets the write key bit.
// - The write key bit always reads back as zero.
// - Latency code 2 means two cycles and 3 means three; other codes are reserved.
// - Writing latency, key, bank count or page size starts SDRAM initialization.
// - Bits 6-4 give the bank count: 0 one, 1 two, 2 four; others reserved.
// - Bits 2-0 give column bits 8 to 11 for codes 0 to 3; others reserved.
// - Reserved config bits 7 and 3 and refresh bits 31-13 read as zero.
// - Bits 12-0 of refresh control set the refresh period, reset value 4E2h.
// - A written refresh rate below 20h is replaced by twice the refresh cycle time plus one.
// - A write touching the lower three config bytes starts init; upper byte alone does not.
`timescale 1ns/1ps
module scr_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [1:0]  cas_latency_o,
    output logic      [2:0]  bank_count_o,
    output logic      [3:0]  column_bits_o,
    output logic             init_start_o,
    output logic             refresh_req_o
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        req;
    logic        wr;
    logic        cfg_wr;
    logic        rate_wr;
    logic        trfc_wr;
    logic        low_touch;
    logic [31:0] rd_data;
    logic [2:0]  cas_latency_field_reg;
    logic [2:0]  internal_bank_count_reg;
    logic [2:0]  column_page_size_reg;
    logic [12:0] refresh_interval_reg;
    logic [12:0] refresh_interval_next;
    logic [3:0]  refresh_cycle_time_reg;
    logic [12:0] count_reg;
    logic        count_done;

    assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr        = req && wb_we_i;
    assign cfg_wr    = wr && (wb_adr_i == scr_pkg::CONFIG_OFFSET);
    assign rate_wr   = wr && (wb_adr_i == scr_pkg::REFRESH_OFFSET) && (wb_sel_i[1:0] != 2'b00);
    assign trfc_wr   = wr && (wb_adr_i == scr_pkg::TIMING_OFFSET) && wb_sel_i[0];
    assign low_touch = cfg_wr && (wb_sel_i[2:0] != 3'b000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        rd_data = scr_pkg::UNMAPPED_DATA;
        case (wb_adr_i)
            scr_pkg::CONFIG_OFFSET: begin
                // Key bit, bits 7 and 3 read zero
                rd_data[scr_pkg::CL_LSB +: 3]   = cas_latency_field_reg;
                rd_data[scr_pkg::BANK_LSB +: 3] = internal_bank_count_reg;
                rd_data[scr_pkg::PAGE_LSB +: 3] = column_page_size_reg;
            end
            scr_pkg::REFRESH_OFFSET: begin
                rd_data[12:0] = refresh_interval_reg;
            end
            scr_pkg::TIMING_OFFSET: begin
                rd_data[scr_pkg::TRFC_LSB +: 4] = refresh_cycle_time_reg;
            end
            scr_pkg::STATUS_OFFSET: begin
                rd_data[12:0] = count_reg;
            end
            default: begin
                rd_data = scr_pkg::UNMAPPED_DATA;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cas_latency_field_reg <= scr_pkg::CL_RESET;
        end else if (cfg_wr && wb_sel_i[1] && wb_dat_i[scr_pkg::KEY_BIT]) begin
            cas_latency_field_reg <= wb_dat_i[scr_pkg::CL_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_bank_count_reg <= scr_pkg::BANK_RESET;
            column_page_size_reg    <= scr_pkg::PAGE_RESET;
        end else if (cfg_wr && wb_sel_i[0]) begin
            internal_bank_count_reg <= wb_dat_i[scr_pkg::BANK_LSB +: 3];
            column_page_size_reg    <= wb_dat_i[scr_pkg::PAGE_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cas_latency_o <= 2'h3;
            bank_count_o  <= 3'h4;
            column_bits_o <= 4'h8;
        end else begin
            // Reserved codes hold the previous decode
            case (cas_latency_field_reg)
                3'h2:    cas_latency_o <= 2'h2;
                3'h3:    cas_latency_o <= 2'h3;
                default: cas_latency_o <= cas_latency_o;
            endcase
            case (internal_bank_count_reg)
                3'h0:    bank_count_o <= 3'h1;
                3'h1:    bank_count_o <= 3'h2;
                3'h2:    bank_count_o <= 3'h4;
                default: bank_count_o <= bank_count_o;
            endcase
            if (column_page_size_reg < 3'h4) begin
                column_bits_o <= 4'h8 + {1'b0, column_page_size_reg};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_start_o <= 1'b0;
        end else begin
            init_start_o <= low_touch;
        end
    end

    // ------------------------------------------------------------
    // Refresh rate and counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_cycle_time_reg <= scr_pkg::TRFC_RESET;
        end else if (trfc_wr) begin
            refresh_cycle_time_reg <= wb_dat_i[scr_pkg::TRFC_LSB +: 4];
        end
    end

    always_comb begin
        refresh_interval_next = refresh_interval_reg;
        if (wb_sel_i[0]) begin
            refresh_interval_next[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            refresh_interval_next[12:8] = wb_dat_i[12:8];
        end
        if (refresh_interval_next < scr_pkg::RATE_MIN) begin
            refresh_interval_next = {8'h00, refresh_cycle_time_reg, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_interval_reg <= scr_pkg::RATE_RESET;
        end else if (rate_wr) begin
            refresh_interval_reg <= refresh_interval_next;
        end
    end

    assign count_done = (count_reg == 13'h0000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg     <= scr_pkg::RATE_RESET;
            refresh_req_o <= 1'b0;
        end else begin
            refresh_req_o <= count_done;
            if (count_done) begin
                count_reg <= refresh_interval_reg;
            end else begin
                count_reg <= count_reg - 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_keyed_write;
        cfg_wr && wb_sel_i[1] && wb_dat_i[scr_pkg::KEY_BIT];
    endsequence

    a_cl_key_guard: assert property (@(posedge clk_i) disable iff (rst_i)
        !(cfg_wr && wb_sel_i[1] && wb_dat_i[scr_pkg::KEY_BIT])
        |=> $stable(cas_latency_field_reg))
        else $error("latency changed without key");
    a_cl_key_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_keyed_write |=> cas_latency_field_reg == $past(wb_dat_i[11:9]))
        else $error("keyed latency write lost");
    a_key_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == scr_pkg::CONFIG_OFFSET) |=> !wb_dat_o[8])
        else $error("key bit read nonzero");
    a_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == scr_pkg::REFRESH_OFFSET)
        |=> wb_dat_o[31:13] == 19'h0)
        else $error("reserved refresh bits nonzero");
    a_init_start: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_wr |=> init_start_o == ($past(wb_sel_i[2:0]) != 3'b000))
        else $error("init start mismatch");
    a_rate_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        rate_wr |=> refresh_interval_reg >= 13'h0020 ||
                    refresh_interval_reg == {8'h00, $past(refresh_cycle_time_reg), 1'b1})
        else $error("rate floor broken");
    a_refresh_period: assert property (@(posedge clk_i) disable iff (rst_i)
        refresh_req_o && count_reg > 13'h0 |=> !refresh_req_o)
        else $error("refresh request too soon");
    a_reload_count: assert property (@(posedge clk_i) disable iff (rst_i)
        count_done |=> count_reg == $past(refresh_interval_reg)
        ##1 (!refresh_req_o || count_reg == 13'h0))
        else $error("refresh reload wrong");
    a_bank_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_bank_count_reg == 3'h2 |=> bank_count_o == 3'h4)
        else $error("bank decode wrong");

    // ------------------------------------------------------------
    // Checks: decoded outputs and init start
    // ------------------------------------------------------------
    a_cl_decode_two: assert property (@(posedge clk_i) disable iff (rst_i)
        cas_latency_field_reg == 3'h2 |=> cas_latency_o == 2'h2)
        else $error("latency code two decode wrong");
    a_cl_decode_three: assert property (@(posedge clk_i) disable iff (rst_i)
        cas_latency_field_reg == 3'h3 |=> cas_latency_o == 2'h3)
        else $error("latency code three decode wrong");
    a_cl_reserved_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(cas_latency_field_reg inside {3'h2, 3'h3}) |=> $stable(cas_latency_o))
        else $error("reserved latency code changed decode");
    a_bank_one: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_bank_count_reg == 3'h0 |=> bank_count_o == 3'h1)
        else $error("one bank decode wrong");
    a_bank_two: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_bank_count_reg == 3'h1 |=> bank_count_o == 3'h2)
        else $error("two bank decode wrong");
    a_bank_reserved_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_bank_count_reg > 3'h2 |=> $stable(bank_count_o))
        else $error("reserved bank code changed decode");
    a_page_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        column_page_size_reg < 3'h4 |=> column_bits_o == 4'h8 + {1'b0, $past(column_page_size_reg)})
        else $error("column bits decode wrong");
    a_page_reserved_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        column_page_size_reg > 3'h3 |=> $stable(column_bits_o))
        else $error("reserved page code changed decode");
    a_init_lane_low: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_wr && wb_sel_i[1:0] != 2'b00 |=> init_start_o)
        else $error("field write did not start init");
    a_init_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        init_start_o |=> !init_start_o)
        else $error("init start longer than one cycle");
    a_init_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg_wr |=> !init_start_o)
        else $error("init start without config write");

    // ------------------------------------------------------------
    // Checks: read data and refresh
    // ------------------------------------------------------------
    sequence s_cfg_read;
        req && !wb_we_i && wb_adr_i == scr_pkg::CONFIG_OFFSET;
    endsequence

    sequence s_rate_read;
        req && !wb_we_i && wb_adr_i == scr_pkg::REFRESH_OFFSET;
    endsequence

    sequence s_rate_write;
        rate_wr;
    endsequence

    a_resv_cfg_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cfg_read
        |=> wb_dat_o[31:12] == 20'h0 && !wb_dat_o[7] && !wb_dat_o[3])
        else $error("reserved config bits nonzero");
    a_rate_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !rate_wr |=> $stable(refresh_interval_reg))
        else $error("refresh rate changed without write");
    a_rate_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rate_write ##0 (refresh_interval_next >= scr_pkg::RATE_MIN)
        |=> refresh_interval_reg == $past(refresh_interval_next))
        else $error("refresh rate write lost");
    a_rate_read: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rate_read |=> wb_dat_o[12:0] == $past(refresh_interval_reg))
        else $error("refresh rate read wrong");
    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        !count_done |=> count_reg == $past(count_reg) - 13'h0001)
        else $error("refresh counter step wrong");
    a_refresh_req: assert property (@(posedge clk_i) disable iff (rst_i)
        count_done |=> refresh_req_o)
        else $error("refresh request missing");
    a_refresh_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !count_done |=> !refresh_req_o)
        else $error("refresh request without expiry");
endmodule : scr_regs

// *** src/scr_pkg.sv ***
package scr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CONFIG_OFFSET    = 8'h00;
    localparam logic [7:0]  REFRESH_OFFSET   = 8'h04;
    localparam logic [7:0]  TIMING_OFFSET    = 8'h08;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h0C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CL_LSB           = 9;
    localparam int          KEY_BIT          = 8;
    localparam int          BANK_LSB         = 4;
    localparam int          PAGE_LSB         = 0;
    localparam int          TRFC_LSB         = 0;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [2:0]  CL_RESET         = 3'h3;
    localparam logic [2:0]  BANK_RESET       = 3'h2;
    localparam logic [2:0]  PAGE_RESET       = 3'h0;
    localparam logic [12:0] RATE_RESET       = 13'h04E2;
    localparam logic [12:0] RATE_MIN         = 13'h0020;
    localparam logic [3:0]  TRFC_RESET       = 4'h0;
    localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage : scr_pkg

// *** sim/scr_sdram_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Far-side memory: counts init and refresh
// ----------------------------------------
module scr_sdram_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic init_start_i,
    input  wire logic refresh_req_i,
    output int        init_cnt_o,
    output int        ref_cnt_o,
    output int        ref_gap_o
);
    int cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_cnt_o <= 0;
            ref_cnt_o  <= 0;
            ref_gap_o  <= 0;
            cnt        <= 0;
        end else begin
            init_cnt_o <= init_cnt_o + int'(init_start_i);
            cnt        <= refresh_req_i ? 1 : cnt + 1;
            if (refresh_req_i) begin
                ref_cnt_o <= ref_cnt_o + 1;
                ref_gap_o <= cnt;
            end
        end
    end
endmodule : scr_sdram_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        clk_i, rst_i, cyc, stb, we, ini, rfq;
    logic [7:0]  adr;
    logic [3:0]  sel, col, trfc;
    logic [31:0] wdat, rd, d, r, odat;
    logic [1:0]  cas;
    logic [2:0]  bnk, cl, bank, page;
    logic        ack;
    logic [8:0]  dexp;
    int          fails, samples_checked, ic, rc, gap, n0;
    logic [31:0] rv [4] = '{32'h1F, 32'h1FFF, 32'h0, 32'h20};
    // ----------------------------------------
    // Design, partner, clock, watchdog
    // ----------------------------------------
    scr_regs scr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(odat),
        .wb_ack_o(ack), .cas_latency_o(cas), .bank_count_o(bnk), .column_bits_o(col),
        .init_start_o(ini), .refresh_req_o(rfq));
    scr_sdram_model scr_sdram_model_inst (.clk_i(clk_i), .rst_i(rst_i), .init_start_i(ini),
        .refresh_req_i(rfq), .init_cnt_o(ic), .ref_cnt_o(rc), .ref_gap_o(gap));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        results();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] v);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= v;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = odat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    function automatic logic [8:0] dec_exp(input logic [2:0] c, input logic [2:0] b,
                                           input logic [2:0] p, input logic [8:0] prev);
        dec_exp = prev;
        if (c == 3'h2 || c == 3'h3) dec_exp[8:7] = c[1:0];
        if (b < 3'h3) dec_exp[6:4] = 3'h1 << b;
        if (p < 3'h4) dec_exp[3:0] = 4'h8 + {1'b0, p};
    endfunction : dec_exp
    task automatic wcfg(input logic [31:0] v, input logic [3:0] s);
        n0 = ic;
        bus(1'b1, 8'h00, s, v);
        if (s[0]) {bank, page} = {v[6:4], v[2:0]};
        if (s[1] && v[8]) cl = v[11:9];
        chk(32'(ic), 32'(n0 + int'(s[2:0] != 3'h0)));
        bus(1'b0, 8'h00, 4'hF, 32'h0);
        chk(rd, {20'h0, cl, 2'h0, bank, 1'b0, page});
        dexp = dec_exp(cl, bank, page, dexp);
        chk(32'({cas, bnk, col}), 32'(dexp));
    endtask : wcfg
    task automatic results();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_i = 1'b1;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 8'h00;
        sel   = 4'h0;
        wdat  = 32'h0;
        r     = 32'hDD33;
        cl    = 3'h3;
        bank  = 3'h2;
        page  = 3'h0;
        trfc  = 4'h5;
        dexp  = {2'h3, 3'h4, 4'h8};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h00, 4'hF, 32'h0);
        chk(rd, 32'h0000_0620);
        bus(1'b0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h0000_04E2);
        wcfg(32'h0000_0400, 4'hF);
        wcfg(32'h0000_0500, 4'hF);
        wcfg(32'h0000_0700, 4'h2);
        wcfg(32'h0000_0521, 4'h8);
        wcfg(32'h0000_0B77, 4'h3);
        for (int i = 0; i < 20; i++) begin
            r = lfsr(r);
            d = {20'h0, 3'(3'h2 + r[0]), r[5], 1'b0, 3'(r[2:1] % 2'h3), 2'h0, r[4:3]};
            wcfg(d, r[9:6]);
        end
        bus(1'b1, 8'h08, 4'hF, 32'h5);
        foreach (rv[i]) begin
            bus(1'b1, 8'h04, 4'hF, rv[i]);
            bus(1'b0, 8'h04, 4'hF, 32'h0);
            chk(rd, (rv[i] < 32'h20) ? 32'(2 * trfc + 1) : rv[i]);
        end
        n0 = rc;
        for (int k = 0; k < 3000 && rc < n0 + 2; k++) @(posedge clk_i);
        chk(32'(gap), 32'h21);
        bus(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        bus(1'b0, 8'h10, 4'hF, 32'h0);
        chk(rd, 32'h0);
        results();
    end
endmodule : testbench
